// ### bench/spd_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module spd_core_model (
  // Clock
  input  wire logic       clk_i,
  // Access request
  output logic [7:0]      addr_o,
  output logic            rd_o,
  output logic            wr_o,
  output logic [7:0]      data_o,
  output logic            bit_mode_o,
  output logic [2:0]      bit_pos_o,
  output logic            bit_val_o
);
  assign bit_pos_o = data_o[2:0];
  assign bit_val_o = data_o[7];
  initial {addr_o, rd_o, wr_o, data_o, bit_mode_o} = '0;
  // One access held over one rising edge, data inverted after
  task acc(input logic r, w, b, input logic [7:0] a, d);
    @(negedge clk_i);
    {addr_o, rd_o, wr_o, data_o, bit_mode_o} = {a, r, w, d, b};
    @(negedge clk_i);
    {rd_o, wr_o, bit_mode_o} = 3'h0;
    data_o = ~d;
  endtask
endmodule
`default_nettype wire

// ### bench/spd_decoder_checker.sv
`timescale 1ns/1ps
`default_nettype none
module spd_decoder_checker (
  // Watched ports
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic [7:0] addr_i,
  input wire logic       rd_i,
  input wire logic       wr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic       bit_mode_i,
  input wire logic [7:0] rd_data_o,
  input wire logic       rd_valid_o,
  input wire logic       bit_refused_o,
  input wire logic [7:0] register_page_select_o,
  input wire logic [7:0] converter_accum_config_o,
  input wire logic [7:0] converter_burst_powerup_time_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Byte write of the current access
  wire logic bw = wr_i && !bit_mode_i;
  wire logic [7:0] pg = register_page_select_o;
  chk_valid_pulse: assert property (rd_i |=> rd_valid_o)
    else $error("read valid missing");
  chk_valid_cause: assert property (rd_valid_o |-> $past(rd_i))
    else $error("stray read valid");
  chk_page_write: assert property (bw && addr_i == 8'ha7
    |=> pg == $past(wr_data_i)) else $error("page write lost");
  chk_page_read: assert property (rd_i && !wr_i && addr_i == 8'ha7
    |=> rd_data_o == $past(pg)) else $error("page read wrong");
  chk_burst_write: assert property (bw && addr_i == 8'hba && pg == 8'h0f
    |=> converter_burst_powerup_time_o == $past(wr_data_i))
    else $error("high page write lost");
  chk_accum_keep: assert property (bw && addr_i == 8'hba && pg == 8'h0f
    |=> $stable(converter_accum_config_o)) else $error("low page hit");
  chk_accum_write: assert property (bw && addr_i == 8'hba && pg == 8'h00
    |=> converter_accum_config_o == $past(wr_data_i))
    else $error("low page write lost");
  chk_bit_refuse: assert property (wr_i && bit_mode_i
    && addr_i[2:0] != 3'h0 |-> bit_refused_o) else $error("bit not refused");
  chk_rsvd_read: assert property (rd_i && addr_i == 8'hba && pg != 8'h00
    && pg != 8'h0f |=> rd_data_o == 8'h00) else $error("reserved read data");
endmodule
bind spd_decoder spd_decoder_checker u_chk (
  .clk_i                          (clk_i),
  .sys_rst_i                      (sys_rst_i),
  .addr_i                         (addr_i),
  .rd_i                           (rd_i),
  .wr_i                           (wr_i),
  .wr_data_i                      (wr_data_i),
  .bit_mode_i                     (bit_mode_i),
  .rd_data_o                      (rd_data_o),
  .rd_valid_o                     (rd_valid_o),
  .bit_refused_o                  (bit_refused_o),
  .register_page_select_o         (register_page_select_o),
  .converter_accum_config_o       (converter_accum_config_o),
  .converter_burst_powerup_time_o (converter_burst_powerup_time_o)
);
`default_nettype wire

// ### bench/tb_spd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_spd_decoder;
  logic clk_i = 0, sys_rst_i = 1;
  wire logic [7:0] a, wd, rdat, pg, r0, r1, r2, r3, r4, r5, r6, r7, r8;
  wire logic rd, wr, bm, bv, vld;
  wire logic [2:0] bp;
  int fails = 0, comparisons = 0;
  typedef struct {logic [7:0] page, addr, data, exp;} spd_row_t;
  spd_row_t rows [10] = '{'{8'h00, 8'hba, 8'h11, 8'h11},
    '{8'h0f, 8'hba, 8'h22, 8'h22}, '{8'h00, 8'ha4, 8'h33, 8'h33},
    '{8'h0f, 8'ha4, 8'h44, 8'h44}, '{8'h00, 8'ha5, 8'h55, 8'h55},
    '{8'h0f, 8'ha5, 8'h66, 8'h66}, '{8'h00, 8'h96, 8'h77, 8'h77},
    '{8'h0f, 8'h96, 8'h88, 8'h88}, '{8'h03, 8'he6, 8'h99, 8'h99},
    '{8'h05, 8'hba, 8'hee, 8'h00}};
  always #12.5 clk_i = ~clk_i;
  spd_core_model core (.clk_i(clk_i), .addr_o(a), .rd_o(rd), .wr_o(wr),
    .data_o(wd), .bit_mode_o(bm), .bit_pos_o(bp), .bit_val_o(bv));
  spd_decoder DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(a),
    .rd_i(rd), .wr_i(wr), .wr_data_i(wd), .bit_mode_i(bm), .bit_pos_i(bp),
    .bit_val_i(bv), .rd_data_o(rdat), .rd_valid_o(vld), .bit_refused_o(),
    .register_page_select_o(pg), .ext_irq_enable_one_o(r8),
    .converter_accum_config_o(r0), .converter_burst_powerup_time_o(r1),
    .port_zero_output_mode_o(r2), .port_zero_drive_strength_o(r3),
    .port_one_output_mode_o(r4), .port_one_drive_strength_o(r5),
    .dcdc_config_o(r6), .crc_auto_control_o(r7));
  task check(input logic [71:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog well beyond the planned sequence
  initial begin
    repeat (3000) @(posedge clk_i);
    fails++;
    complete_run;
  end
  initial begin
    repeat (20) @(negedge clk_i);
    sys_rst_i = 0;
    check({pg, r0, r1, r2}, 0);
    foreach (rows[i]) begin
      core.acc(0, 1, 0, 8'ha7, rows[i].page);
      core.acc(0, 1, 0, rows[i].addr, rows[i].data);
      core.acc(1, 0, 0, 8'ha7, 0);
      check(rdat, rows[i].page);
      core.acc(1, 0, 0, rows[i].addr, 0);
      check(rdat, rows[i].exp);
      check(vld, 1);
    end
    check({r0, r1, r2, r3, r4, r5, r6, r7, r8}, 72'h112233445566778899);
    // Mid-run reset from a reserved page
    @(negedge clk_i) sys_rst_i = 1;
    @(negedge clk_i) sys_rst_i = 0;
    check({pg, r0, r8}, 0);
    core.acc(0, 1, 1, 8'ha4, 8'hff);
    check(r2, 0);
    core.acc(0, 1, 0, 8'ha7, 8'h0f);
    core.acc(0, 1, 0, 8'ha4, 8'h5c);
    core.acc(0, 1, 0, 8'ha7, 8'h00);
    check({pg, r2, r3}, 24'h00005c);
    complete_run;
  end
endmodule
`default_nettype wire

// ### common/spd_defs.vh
`ifndef SPD_DEFS_VH
`define SPD_DEFS_VH

// Register space window and page values
`define SPD_SPACE_BASE      8'h80
`define SPD_PAGE_ZERO       8'h00
`define SPD_PAGE_HIGH       8'h0f
`define SPD_PAGE_RESET      8'h00
`define SPD_REG_RESET       8'h00

// Addresses decoded on every page
`define SPD_ADDR_PAGE_SEL   8'ha7
`define SPD_ADDR_EIE_ONE    8'he6

// Page-dependent addresses
`define SPD_ADDR_CONV       8'hba
`define SPD_ADDR_PORT0      8'ha4
`define SPD_ADDR_PORT1      8'ha5
`define SPD_ADDR_DCDC       8'h96

// Target selector indices
`define SPD_SEL_NONE        4'h0
`define SPD_SEL_PAGE        4'h1
`define SPD_SEL_EIE_ONE     4'h2
`define SPD_SEL_ACCUM_CFG   4'h3
`define SPD_SEL_BURST_PWR   4'h4
`define SPD_SEL_P0_MODE     4'h5
`define SPD_SEL_P0_DRIVE    4'h6
`define SPD_SEL_P1_MODE     4'h7
`define SPD_SEL_P1_DRIVE    4'h8
`define SPD_SEL_DCDC_CFG    4'h9
`define SPD_SEL_CRC_AUTO    4'ha
`define SPD_NUM_TARGETS     11

// Reserved read value
`define SPD_RSVD_DATA       8'h00

`endif

// ### hw/spd_bit_mask.v
`timescale 1ns/1ps
`default_nettype none

// Byte or single-bit write merge for one target
module spd_bit_mask (
  // Access control
  input  wire       bit_mode_i,
  input  wire [2:0] bit_pos_i,
  input  wire       bit_val_i,
  // Data
  input  wire [7:0] old_data_i,
  input  wire [7:0] wr_data_i,
  output reg  [7:0] new_data_o
);

  // Replace one bit or the whole byte
  always @* begin
    new_data_o = wr_data_i;
    if (bit_mode_i) begin
      new_data_o            = old_data_i;
      new_data_o[bit_pos_i] = bit_val_i;
    end
  end

endmodule
`default_nettype wire

// ### hw/spd_decoder.v
// Overview of operation
// - Page-select register, 8 bits, read/write at 0xA7 on every page.
// - Page-select value chooses the page reached by accesses to paged addresses.
// - Unmapped addresses are reserved; reads return zero, writes do nothing.
// - 0xBA reaches accumulator config on page 0, burst power-up on 0xF.
// - 0xA4 reaches port 0 output mode on page 0, drive on 0xF.
// - 0xA5 reaches port 1 output mode on page 0, drive on 0xF.
// - 0x96 reaches dc-dc config on page 0, CRC auto control on 0xF.
// - All-page registers like ext irq enable one decode on any page.
// - Page select resets to zero so accesses start on page 0.
// - Addresses from 0x80 up ending 0x0 or 0x8 allow bit access; others byte only.
`timescale 1ns/1ps
`default_nettype none
`include "spd_defs.vh"

module spd_decoder (
  // Clock and reset
  input  wire        clk_i,
  input  wire        sys_rst_i,
  // Core access port
  input  wire [7:0]  addr_i,
  input  wire        rd_i,
  input  wire        wr_i,
  input  wire [7:0]  wr_data_i,
  input  wire        bit_mode_i,
  input  wire [2:0]  bit_pos_i,
  input  wire        bit_val_i,
  output reg  [7:0]  rd_data_o,
  output reg         rd_valid_o,
  output wire        bit_refused_o,
  // Page select and all-page contents
  output wire [7:0]  register_page_select_o,
  output wire [7:0]  ext_irq_enable_one_o,
  // Converter contents
  output wire [7:0]  converter_accum_config_o,
  output wire [7:0]  converter_burst_powerup_time_o,
  // Port contents
  output wire [7:0]  port_zero_output_mode_o,
  output wire [7:0]  port_zero_drive_strength_o,
  output wire [7:0]  port_one_output_mode_o,
  output wire [7:0]  port_one_drive_strength_o,
  // Supply and checksum contents
  output wire [7:0]  dcdc_config_o,
  output wire [7:0]  crc_auto_control_o
);

  // Pick the page-zero or page-high target of a paged address
  function [3:0] pick_page;
    input [7:0] page;
    input [3:0] low_sel;
    input [3:0] high_sel;
    begin
      pick_page = `SPD_SEL_NONE;
      if (page == `SPD_PAGE_ZERO) begin
        pick_page = low_sel;
      end else if (page == `SPD_PAGE_HIGH) begin
        pick_page = high_sel;
      end
    end
  endfunction

  // Map address and page to a target index
  function [3:0] target_of;
    input [7:0] addr;
    input [7:0] page;
    begin
      case (addr)
        // Page select is reached the same way on every page
        `SPD_ADDR_PAGE_SEL: target_of = `SPD_SEL_PAGE;
        // All-page registers ignore the page value
        `SPD_ADDR_EIE_ONE:  target_of = `SPD_SEL_EIE_ONE;
        // Accumulator setup or burst power-up time
        `SPD_ADDR_CONV:
          target_of = pick_page(page, `SPD_SEL_ACCUM_CFG,
                                `SPD_SEL_BURST_PWR);
        // Port 0 output mode or drive strength
        `SPD_ADDR_PORT0:
          target_of = pick_page(page, `SPD_SEL_P0_MODE,
                                `SPD_SEL_P0_DRIVE);
        // Port 1 output mode or drive strength
        `SPD_ADDR_PORT1:
          target_of = pick_page(page, `SPD_SEL_P1_MODE,
                                `SPD_SEL_P1_DRIVE);
        // Supply converter setup or checksum automatic control
        `SPD_ADDR_DCDC:
          target_of = pick_page(page, `SPD_SEL_DCDC_CFG,
                                `SPD_SEL_CRC_AUTO);
        // Unmapped addresses, and paged ones on other pages, are reserved
        default:
          target_of = `SPD_SEL_NONE;
      endcase
    end
  endfunction

  // Bit access allowed only at column 0 or 8
  function bit_ok;
    input [7:0] addr;
    begin
      bit_ok = (addr[2:0] == 3'h0) && (addr >= `SPD_SPACE_BASE);
    end
  endfunction

  // Decode state of the current access
  wire [7:0]                  regs [0:`SPD_NUM_TARGETS-1];
  wire [`SPD_NUM_TARGETS-1:1] wr_sel;
  wire [3:0]                  target;
  wire [7:0]                  cur_data;
  wire [7:0]                  merged;
  wire                        bit_ok_now;
  wire                        wr_legal;
  wire                        rd_hit;
  reg  [7:0]                  page_sel;
  reg  [7:0]                  next_rd_data;

  // Current page steers the decode of paged addresses
  // The decode never yields an index past the last target, so the
  // read of the byte array below stays inside its bounds
  assign target        = target_of(addr_i, page_sel);
  assign cur_data      = regs[target];
  assign bit_ok_now    = bit_ok(addr_i);
  assign bit_refused_o = bit_mode_i && (rd_i || wr_i) && !bit_ok_now;

  // Write qualification shared by every target
  // A refused bit write must leave every byte alone, so the strobe
  // is cut here once instead of in each storage byte
  assign wr_legal = wr_i && (!bit_mode_i || bit_ok_now);
  assign rd_hit   = (target != `SPD_SEL_NONE);

  // Merge single-bit writes
  spd_bit_mask u_mask (
    .bit_mode_i (bit_mode_i),
    .bit_pos_i  (bit_pos_i),
    .bit_val_i  (bit_val_i),
    .old_data_i (cur_data),
    .wr_data_i  (wr_data_i),
    .new_data_o (merged)
  );

  // One write strobe per target, at most one high in a cycle
  genvar gi;
  generate
    for (gi = `SPD_SEL_PAGE; gi < `SPD_NUM_TARGETS; gi = gi + 1) begin : g_sel
      assign wr_sel[gi] = wr_legal && ({28'h0000000, target} == gi);
    end
  endgenerate

  // Page select; cleared by reset so the core starts on page zero
  // A new page takes effect from the access after the write
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      page_sel <= `SPD_PAGE_RESET;
    end else if (wr_sel[`SPD_SEL_PAGE]) begin
      page_sel <= merged;
    end
  end

  // Reserved slot has no storage and reads as the filler byte
  assign regs[`SPD_SEL_NONE] = `SPD_RSVD_DATA;
  assign regs[`SPD_SEL_PAGE] = page_sel;

  // One storage byte per peripheral target; each has its own process
  generate
    for (gi = `SPD_SEL_EIE_ONE; gi < `SPD_NUM_TARGETS; gi = gi + 1) begin : g_r
      reg [7:0] slot_q;
      // Holds its byte until its own strobe fires
      always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          slot_q <= `SPD_REG_RESET;
        end else if (wr_sel[gi]) begin
          slot_q <= merged;
        end
      end
      assign regs[gi] = slot_q;
    end
  endgenerate

  // Byte that a read in this cycle captures
  always @* begin
    next_rd_data = `SPD_RSVD_DATA;
    if (rd_hit) begin
      next_rd_data = cur_data;
    end
  end

  // Registered read data
  // A read beside a write to the same byte returns the old byte,
  // since both sample the storage before the edge updates it
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_data_o  <= `SPD_RSVD_DATA;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_i;
      if (rd_i) begin
        rd_data_o <= next_rd_data;
      end
    end
  end

  // Page select and all-page contents
  assign register_page_select_o         = regs[`SPD_SEL_PAGE];
  assign ext_irq_enable_one_o           = regs[`SPD_SEL_EIE_ONE];
  // Paged contents, one byte per address on page 0 and on page 0xF
  assign converter_accum_config_o       = regs[`SPD_SEL_ACCUM_CFG];
  assign converter_burst_powerup_time_o = regs[`SPD_SEL_BURST_PWR];
  assign port_zero_output_mode_o        = regs[`SPD_SEL_P0_MODE];
  assign port_zero_drive_strength_o     = regs[`SPD_SEL_P0_DRIVE];
  assign port_one_output_mode_o         = regs[`SPD_SEL_P1_MODE];
  assign port_one_drive_strength_o      = regs[`SPD_SEL_P1_DRIVE];
  assign dcdc_config_o                  = regs[`SPD_SEL_DCDC_CFG];
  assign crc_auto_control_o             = regs[`SPD_SEL_CRC_AUTO];

endmodule
`default_nettype wire
